/* File: pkg/ssa_pkg.sv */
// constants, register map and types of the stream scan acquisition block
// How it works
// - each scan starts one scan period after the last; channels are spaced by the resolution's interchannel delay
// - samples wait in an on-board fifo, depth 984 by default, down to 512
// - on overflow timing keeps running, new samples drop until the fifo is empty
// - packets dropped during recovery are counted and readable by the host
// - four resolution settings, 2500 to 50000 samples per second aggregate
// - channel spacing inside a scan is 320, 82, 42 or 12.5 us by resolution
// - code 193 returns extended lines in the upper byte, low lines in the lower
// - codes 200, 201, 210, 211 return the low word of that timer or counter
// - sampling a timer or counter low word captures its high word at once
// - code 224 returns the captured high word; host orders entries accordingly
// - special channels never reconfigure lines; digital word always reads cleanly
// - no system timer upper half is offered as a stream source
package ssa_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam real ICD0_US = 320.0;
  localparam real ICD1_US = 82.0;
  localparam real ICD2_US = 42.0;
  localparam real ICD3_US = 12.5;
  localparam int ICD0_CYC = int'($ceil(ICD0_US * 1000.0 / CLK_PERIOD_NS));
  localparam int ICD1_CYC = int'($ceil(ICD1_US * 1000.0 / CLK_PERIOD_NS));
  localparam int ICD2_CYC = int'($ceil(ICD2_US * 1000.0 / CLK_PERIOD_NS));
  localparam int ICD3_CYC = int'($ceil(ICD3_US * 1000.0 / CLK_PERIOD_NS));
  localparam int MAX_RATE0 = 2500;
  localparam int MAX_RATE1 = 10000;
  localparam int MAX_RATE2 = 20000;
  localparam int MAX_RATE3 = 50000;
  localparam int FIFO_DEPTH_MAX = 984;
  localparam int FIFO_DEPTH_MIN = 512;
  localparam int PKT_SAMPLES_DEF = 24;
  localparam int SAMPLE_W = 16;
  localparam int LIST_MAX = 8;
  localparam int RES_W = 2;
  localparam int EV_W = 3;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_RES_LSB = 1;
  localparam int EV_OVF = 0;
  localparam int EV_RECOV = 1;
  localparam int EV_SCAN = 2;
  localparam logic [1:0] RES_FULL = 2'h0;
  localparam logic [1:0] RES_MID = 2'h1;
  localparam logic [1:0] RES_HIGH = 2'h2;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PERIOD = 8'h04;
  localparam logic [7:0] REG_LEN = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_MASK = 8'h10;
  localparam logic [7:0] REG_DATA = 8'h14;
  localparam logic [7:0] REG_LEVEL = 8'h18;
  localparam logic [7:0] REG_DROP = 8'h1C;
  localparam logic [7:0] REG_CAPT = 8'h20;
  localparam logic [2:0] REG_LIST_TOP = 3'h2;
  localparam logic [31:0] PERIOD_RST = 32'h0000_2710;
  localparam logic [3:0] LEN_RST = 4'h1;
  localparam logic [7:0] CODE_ANALOG_END = 8'h20;
  localparam logic [7:0] CODE_DIO = 8'hC1;
  localparam logic [7:0] CODE_T0 = 8'hC8;
  localparam logic [7:0] CODE_T1 = 8'hC9;
  localparam logic [7:0] CODE_C0 = 8'hD2;
  localparam logic [7:0] CODE_C1 = 8'hD3;
  localparam logic [7:0] CODE_CAP = 8'hE0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_GAP = 2'b10
  } ssa_state_t;

  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_CTRL = 4'h1,
    SEL_PERIOD = 4'h2,
    SEL_LEN = 4'h3,
    SEL_STATUS = 4'h4,
    SEL_MASK = 4'h5,
    SEL_DATA = 4'h6,
    SEL_LEVEL = 4'h7,
    SEL_DROP = 4'h8,
    SEL_CAPT = 4'h9,
    SEL_LIST = 4'hA
  } ssa_sel_t;

  function automatic ssa_sel_t ssa_decode(input logic [7:0] a);
    if (a[7:5] == REG_LIST_TOP) return SEL_LIST;
    else if (a == REG_CTRL) return SEL_CTRL;
    else if (a == REG_PERIOD) return SEL_PERIOD;
    else if (a == REG_LEN) return SEL_LEN;
    else if (a == REG_STATUS) return SEL_STATUS;
    else if (a == REG_MASK) return SEL_MASK;
    else if (a == REG_DATA) return SEL_DATA;
    else if (a == REG_LEVEL) return SEL_LEVEL;
    else if (a == REG_DROP) return SEL_DROP;
    else if (a == REG_CAPT) return SEL_CAPT;
    else return SEL_NONE;
  endfunction : ssa_decode

  function automatic logic ssa_is_tc(input logic [7:0] c);
    return (c == CODE_T0) || (c == CODE_T1) || (c == CODE_C0) || (c == CODE_C1);
  endfunction : ssa_is_tc
endpackage : ssa_pkg

/* File: pkg/ssa_mem_if.sv */
`timescale 1ns/1ns
// write and read port bundle between the sequencer and the sample memory
interface ssa_mem_if #(parameter int DW = 16, parameter int AW = 10);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface : ssa_mem_if

/* File: rtl/ssa_mem.sv */
`timescale 1ns/1ns
// sample memory with registered read data
module ssa_mem #(
  parameter int DW = 16,
  parameter int AW = 10
) (
  // clock and enable
  input wire logic mclk,
  input wire logic ce,
  // storage port
  ssa_mem_if.mem port
);
  logic [DW-1:0] store [2**AW];

  always_ff @(posedge mclk) begin
    if (ce && port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (ce && port.rd_en) begin
      port.rd_data <= store[port.rd_addr];
    end
  end
endmodule : ssa_mem

/* File: rtl/ssa_stream.sv */
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
// stream scan acquisition engine: bus slave, scan sequencer, sample fifo and recovery
module ssa_stream
  import ssa_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_MAX,
  parameter int PKT_SAMPLES = PKT_SAMPLES_DEF,
  parameter int ICD0 = ICD0_CYC,
  parameter int ICD1 = ICD1_CYC,
  parameter int ICD2 = ICD2_CYC,
  parameter int ICD3 = ICD3_CYC
) (
  // clock, reset and enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // converter front end
  input wire logic [15:0] adc_data,
  output logic adc_sample,
  output logic [7:0] adc_channel,
  // digital, timer and counter sources
  input wire logic [7:0] low_digital_lines,
  input wire logic [7:0] extended_digital_lines,
  input wire logic [31:0] first_timer,
  input wire logic [31:0] second_timer,
  input wire logic [31:0] first_counter,
  input wire logic [31:0] second_counter,
  // interrupt
  output logic irq
);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int PW = $clog2(PKT_SAMPLES + 1);

  // bus side state
  logic ap_take;
  logic wr_pend;
  logic rd_p1;
  logic dp_pop;
  ssa_sel_t ap_sel;
  ssa_sel_t dp_sel;
  logic [2:0] dp_idx;
  logic [31:0] rd_value;
  logic [EV_W-1:0] clr;

  // registers
  logic run;
  logic [RES_W-1:0] res;
  logic [31:0] scan_period;
  logic [3:0] list_len;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic [7:0] scan_list [LIST_MAX];
  logic [15:0] dropped_pkts;
  logic [SAMPLE_W-1:0] capture;

  // sequencer
  ssa_state_t st;
  ssa_state_t next_st;
  logic [2:0] idx;
  logic [2:0] next_idx;
  logic [15:0] gap;
  logic [15:0] next_gap;
  logic [7:0] cur_code;
  logic [7:0] next_code;
  logic [31:0] scan_cnt;
  logic [31:0] period_m1;
  logic [2:0] len_m1;
  logic [15:0] icd_cyc;
  logic tick;
  logic last;
  logic sample_now;
  logic tc_hit;
  logic [31:0] tc_value;
  logic [SAMPLE_W-1:0] word;

  // fifo
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic full;
  logic recovering;
  logic store_ok;
  logic drop;
  logic pop;
  logic [PW-1:0] drop_cnt;
  logic pkt_wrap;
  logic [EV_W-1:0] ev;

  ssa_mem_if #(.DW(SAMPLE_W), .AW(AW)) mif ();

  ssa_mem #(.DW(SAMPLE_W), .AW(AW)) u_mem (
    .mclk(mclk),
    .ce(ce),
    .port(mif.mem)
  );

  // bus decode
  assign ap_take = hsel & htrans[1] & hready;
  assign ap_sel = ssa_decode(haddr[7:0]);
  assign hreadyout = ~rd_p1;
  assign hresp = 1'b0;
  assign pop = ap_take & ~hwrite & (ap_sel == SEL_DATA) & (count != '0);
  assign clr = (rd_p1 && dp_sel == SEL_STATUS) ? {EV_W{1'b1}} : '0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      rd_p1 <= 1'b0;
      dp_pop <= 1'b0;
      dp_sel <= SEL_NONE;
      dp_idx <= 3'h0;
    end else if (ce) begin
      if (hreadyout) begin
        wr_pend <= ap_take & hwrite;
        rd_p1 <= ap_take & ~hwrite;
        dp_pop <= pop;
        dp_sel <= ap_take ? ap_sel : SEL_NONE;
        dp_idx <= haddr[4:2];
      end else begin
        rd_p1 <= 1'b0;
      end
    end
  end

  // register writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      run <= 1'b0;
      res <= RES_FULL;
      scan_period <= PERIOD_RST;
      list_len <= LEN_RST;
      mask <= '0;
      for (int i = 0; i < LIST_MAX; i++) begin
        scan_list[i] <= 8'h00;
      end
    end else if (ce && wr_pend) begin
      if (dp_sel == SEL_CTRL) begin
        run <= hwdata[CTRL_RUN_BIT];
        res <= hwdata[CTRL_RES_LSB +: RES_W];
      end else if (dp_sel == SEL_PERIOD) begin
        scan_period <= hwdata;
      end else if (dp_sel == SEL_LEN) begin
        list_len <= hwdata[3:0];
      end else if (dp_sel == SEL_MASK) begin
        mask <= hwdata[EV_W-1:0];
      end else if (dp_sel == SEL_LIST) begin
        scan_list[dp_idx] <= hwdata[7:0];
      end
    end
  end

  // read data, one wait state
  always_comb begin
    rd_value = 32'h0000_0000;
    case (dp_sel)
      SEL_CTRL: rd_value = {29'h0, res, run};
      SEL_PERIOD: rd_value = scan_period;
      SEL_LEN: rd_value = {28'h0, list_len};
      SEL_STATUS: rd_value = {29'h0, status};
      SEL_MASK: rd_value = {29'h0, mask};
      SEL_DATA: rd_value = dp_pop ? {16'h0, mif.rd_data} : 32'h0000_0000;
      SEL_LEVEL: rd_value = 32'(count);
      SEL_DROP: rd_value = {16'h0, dropped_pkts};
      SEL_CAPT: rd_value = {16'h0, capture};
      SEL_LIST: rd_value = {24'h0, scan_list[dp_idx]};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && rd_p1) begin
      hrdata <= rd_value;
    end
  end

  // scan interval timer, start to start
  assign period_m1 = (scan_period == 32'h0) ? 32'h0 : scan_period - 32'h1;
  assign tick = run & (scan_cnt == 32'h0);
  assign len_m1 = (list_len == 4'h0) ? 3'h0 : 3'(list_len - 4'h1);
  assign last = (idx == len_m1);
  assign sample_now = (st == ST_SAMPLE);

  always_ff @(posedge mclk) begin
    if (rst) begin
      scan_cnt <= 32'h0;
    end else if (ce) begin
      if (!run) begin
        scan_cnt <= 32'h0;
      end else if (tick) begin
        scan_cnt <= period_m1;
      end else begin
        scan_cnt <= scan_cnt - 32'h1;
      end
    end
  end

  // channel spacing by resolution
  assign icd_cyc = (res == RES_FULL) ? 16'(ICD0) :
                   (res == RES_MID) ? 16'(ICD1) :
                   (res == RES_HIGH) ? 16'(ICD2) : 16'(ICD3);

  always_comb begin
    next_st = st;
    next_idx = idx;
    next_gap = gap;
    next_code = cur_code;
    case (st)
      ST_IDLE: begin
        if (tick) begin
          next_st = ST_SAMPLE;
          next_idx = 3'h0;
          next_code = scan_list[0];
        end
      end
      ST_SAMPLE: begin
        if (!run || last) begin
          next_st = ST_IDLE;
        end else begin
          next_st = ST_GAP;
          next_gap = icd_cyc - 16'h2;
        end
      end
      ST_GAP: begin
        if (!run) begin
          next_st = ST_IDLE;
        end else if (gap == 16'h0) begin
          next_st = ST_SAMPLE;
          next_idx = 3'(idx + 3'h1);
          next_code = scan_list[3'(idx + 3'h1)];
        end else begin
          next_gap = gap - 16'h1;
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= ST_IDLE;
      idx <= 3'h0;
      gap <= 16'h0;
      cur_code <= 8'h00;
    end else if (ce) begin
      st <= next_st;
      idx <= next_idx;
      gap <= next_gap;
      cur_code <= next_code;
    end
  end

  // sample source selection
  assign adc_channel = cur_code;
  assign adc_sample = sample_now & (cur_code < CODE_ANALOG_END);
  assign tc_hit = ssa_is_tc(cur_code);
  assign tc_value = (cur_code == CODE_T0) ? first_timer :
                    (cur_code == CODE_T1) ? second_timer :
                    (cur_code == CODE_C0) ? first_counter : second_counter;
  assign word = (cur_code < CODE_ANALOG_END) ? adc_data :
                (cur_code == CODE_DIO) ? {extended_digital_lines, low_digital_lines} :
                tc_hit ? tc_value[15:0] :
                (cur_code == CODE_CAP) ? capture : 16'h0000;

  always_ff @(posedge mclk) begin
    if (rst) begin
      capture <= 16'h0000;
    end else if (ce && sample_now && tc_hit) begin
      capture <= tc_value[31:16];
    end
  end

  // fifo control and auto-recovery
  assign full = (count == CW'(FIFO_DEPTH));
  assign store_ok = sample_now & ~recovering & ~full;
  assign drop = sample_now & (recovering | full);
  assign pkt_wrap = drop & (drop_cnt == PW'(PKT_SAMPLES - 1));
  assign mif.wr_en = store_ok;
  assign mif.wr_addr = wr_ptr;
  assign mif.wr_data = word;
  assign mif.rd_en = pop;
  assign mif.rd_addr = rd_ptr;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      recovering <= 1'b0;
    end else if (ce) begin
      if (store_ok) begin
        wr_ptr <= (wr_ptr == AW'(FIFO_DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(FIFO_DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
      count <= CW'(count + CW'(store_ok) - CW'(pop));
      if (sample_now && full && !recovering) begin
        recovering <= 1'b1;
      end else if (recovering && count == '0) begin
        recovering <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      drop_cnt <= '0;
      dropped_pkts <= 16'h0000;
    end else if (ce) begin
      if (drop) begin
        drop_cnt <= pkt_wrap ? '0 : PW'(drop_cnt + 1'b1);
      end
      if (pkt_wrap) begin
        dropped_pkts <= (wr_pend && dp_sel == SEL_DROP) ? 16'h0001 : 16'(dropped_pkts + 16'h1);
      end else if (wr_pend && dp_sel == SEL_DROP) begin
        dropped_pkts <= 16'h0000;
      end
    end
  end

  // sticky events, read clears, set wins
  assign ev[EV_OVF] = sample_now & full & ~recovering;
  assign ev[EV_RECOV] = recovering & (count == '0);
  assign ev[EV_SCAN] = sample_now & last;
  assign irq = |(status & mask);

  always_ff @(posedge mclk) begin
    if (rst) begin
      status <= '0;
    end else if (ce) begin
      status <= (status & ~clr) | ev;
    end
  end

  // helper counters for timing checks
  logic [15:0] since_samp;
  logic [31:0] since_scan;
  logic seen_tick;

  always_ff @(posedge mclk) begin
    if (rst) begin
      since_samp <= 16'h0;
      since_scan <= 32'h0;
      seen_tick <= 1'b0;
    end else if (ce) begin
      since_samp <= sample_now ? 16'h0 : 16'(since_samp + 16'h1);
      since_scan <= tick ? 32'h0 : 32'(since_scan + 32'h1);
      seen_tick <= run & (seen_tick | tick);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || !ce);

  sequence s_overflow_hit;
    sample_now && full && !recovering;
  endsequence

  sequence s_drained;
    recovering && count == '0;
  endsequence

  a_scan_period: assert property (tick && seen_tick |-> since_scan == period_m1)
    else $error("scan start spacing differs from programmed period");
  a_chan_spacing: assert property (sample_now && idx != 3'h0 |-> since_samp == 16'(icd_cyc - 16'h1))
    else $error("interchannel spacing wrong");
  a_enter_recov: assert property (s_overflow_hit |=> recovering && status[EV_OVF])
    else $error("overflow did not start recovery");
  a_drop_recov: assert property (recovering |-> !mif.wr_en)
    else $error("sample stored during recovery");
  a_recov_exit: assert property (s_drained |=> !recovering ##0 status[EV_RECOV])
    else $error("recovery did not end after drain");
  a_drop_count: assert property (pkt_wrap && !(wr_pend && dp_sel == SEL_DROP)
                                 |=> dropped_pkts == 16'($past(dropped_pkts) + 16'h1))
    else $error("dropped packet count not advanced");
  a_dio_word: assert property (sample_now && cur_code == CODE_DIO && !recovering && !full
                               |-> mif.wr_en && mif.wr_data == {extended_digital_lines, low_digital_lines})
    else $error("digital word stored wrongly");
  a_tc_low: assert property (sample_now && cur_code == CODE_C1 && !recovering && !full
                             |-> mif.wr_en && mif.wr_data == second_counter[15:0])
    else $error("counter low word stored wrongly");
  a_high_word_capture: assert property (sample_now && tc_hit |=> capture == $past(tc_value[31:16]))
    else $error("high word not captured");
  a_cap_read: assert property (sample_now && cur_code == CODE_CAP |-> word == capture ##1 capture == $past(capture))
    else $error("capture word not returned");
  a_scan_end: assert property (sample_now && last |=> st == ST_IDLE ##0 status[EV_SCAN])
    else $error("scan did not end at list end");
endmodule : ssa_stream

/* File: dv/ssa_adc_model.sv */
`timescale 1ns/1ns
// converter front end model that answers each sample strobe with a running count
module ssa_adc_model (
  // clock
  input wire logic mclk,
  // converter pins
  input wire logic adc_sample,
  output logic [15:0] adc_data
);
  logic [15:0] cnt = 16'h0000;
  logic [15:0] junk = 16'h5A5A;
  always @(posedge mclk) begin
    junk <= ~junk;
    if (adc_sample === 1'b1) cnt <= cnt + 16'h0001;
  end
  // outside the strobe the result lines carry a changing pattern, never the last value
  assign adc_data = adc_sample ? 16'h1000 + cnt : junk;
endmodule : ssa_adc_model

/* File: dv/test_stream_scan_acquisition.sv */
`timescale 1ns/1ns
// self-checking bench of the stream scan acquisition engine
module test_stream_scan_acquisition;
  import ssa_pkg::*;
  localparam int DEPTH = 8;
  localparam int PKT = 3;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, adc_sample, irq;
  logic [31:0] hrdata;
  logic [15:0] adc_data;
  logic [7:0] adc_channel;
  logic [7:0] low_d = 8'h00;
  logic [7:0] ext_d = 8'h00;
  logic [31:0] t0 = 32'h0, t1 = 32'h0, c0 = 32'h0, c1 = 32'h0;
  int n_errors = 0, checks = 0, cyc = 0, n_pulse = 0;
  int p_time[$];
  logic [15:0] pq[$];
  logic [7:0] ch_q[$];
  logic [31:0] rnd = 32'd26912;
  int icd_v[4] = '{20, 14, 10, 6};

  ssa_stream #(.FIFO_DEPTH(DEPTH), .PKT_SAMPLES(PKT), .ICD0(20), .ICD1(14), .ICD2(10), .ICD3(6)) i_dut (
    .mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .adc_data(adc_data), .adc_sample(adc_sample), .adc_channel(adc_channel),
    .low_digital_lines(low_d), .extended_digital_lines(ext_d), .first_timer(t0), .second_timer(t1),
    .first_counter(c0), .second_counter(c1), .irq(irq));
  ssa_adc_model i_adc (.mclk(mclk), .adc_sample(adc_sample), .adc_data(adc_data));

  always #5 mclk = ~mclk;

  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction : xs

  task wrap_up;
    $display("Counts: %0d comparisons, %0d mismatches", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // sample strobe monitor, expected analog values and run limit
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (adc_sample === 1'b1) begin
      p_time.push_back(cyc);
      pq.push_back(16'h1000 + n_pulse[15:0]);
      ch_q.push_back(adc_channel);
      n_pulse++;
    end
    if (cyc > 60000) begin
      n_errors++;
      wrap_up();
    end
  end

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task chk_cyc(input int got, input int exp);
    checks++;
    if (got != exp) begin
      n_errors++;
      $display("Error at %0t: gap %h expected %h", $time, got, exp);
    end
  endtask : chk_cyc

  // address phase held until hready is seen high at a rising edge, then the data phase likewise
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd_v);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd_v = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk_word(x, exp);
  endtask : rd

  task flush;
    rd(REG_LEVEL, pq.size());
    while (pq.size() > 0) rd(REG_DATA, {16'h0, pq.pop_front()});
    p_time.delete();
    ch_q.delete();
  endtask : flush

  initial begin
    logic [31:0] x;
    logic [7:0] codes[8];
    logic [15:0] e[8];
    int g;
    codes = '{CODE_DIO, CODE_T0, CODE_CAP, CODE_C1, CODE_CAP, 8'h03, CODE_T1, CODE_C0};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd(REG_CTRL, 32'h0);
    rd(REG_PERIOD, PERIOD_RST);
    rd(REG_LEN, {28'h0, LEN_RST});
    rd(8'h30, 32'h0);
    rd(REG_DATA, 32'h0);
    wr(REG_LEVEL, 32'hFF);
    rd(REG_LEVEL, 32'h0);
    $display("test reset values finished");
    wr(8'h40, 32'h0);
    wr(8'h44, 32'h5);
    wr(REG_LEN, 32'h2);
    wr(REG_PERIOD, 32'd1000);
    for (int r = 0; r < 4; r++) begin
      wr(REG_CTRL, 32'h1 | (r << 1));
      while (pq.size() < 2) @(posedge mclk);
      wr(REG_CTRL, 32'h0);
      chk_cyc(p_time[1] - p_time[0], icd_v[r]);
      chk_word({ch_q[0], ch_q[1]}, 32'h0005);
      flush();
    end
    $display("test channel spacing finished");
    rd(REG_STATUS, 32'h4);
    wr(REG_MASK, 32'h4);
    chk_word({31'h0, irq}, 32'h0);
    wr(REG_LEN, 32'h1);
    wr(REG_PERIOD, 32'd60);
    wr(REG_CTRL, 32'h1);
    while (pq.size() < 3) @(posedge mclk);
    chk_word({31'h0, irq}, 32'h1);
    wr(REG_CTRL, 32'h0);
    chk_cyc(p_time[2] - p_time[1], 60);
    repeat (3) @(posedge mclk);
    rd(REG_STATUS, 32'h4);
    chk_word({31'h0, irq}, 32'h0);
    flush();
    $display("test scan period finished");
    x = xs();
    low_d <= x[7:0];
    ext_d <= x[15:8];
    t0 <= xs();
    t1 <= xs();
    c0 <= xs();
    c1 <= xs();
    for (int i = 0; i < 8; i++) wr(8'(8'h40 + 4 * i), {24'h0, codes[i]});
    wr(REG_LEN, 32'h8);
    wr(REG_PERIOD, 32'd5000);
    wr(REG_CTRL, 32'h7);
    while (irq !== 1'b1) @(posedge mclk);
    wr(REG_CTRL, 32'h0);
    e = '{{ext_d, low_d}, t0[15:0], t0[31:16], c1[15:0], c1[31:16], pq.pop_front(), t1[15:0], c0[15:0]};
    rd(REG_LEVEL, 32'h8);
    for (int i = 0; i < 8; i++) rd(REG_DATA, {16'h0, e[i]});
    rd(REG_CAPT, {16'h0, c0[31:16]});
    rd(REG_STATUS, 32'h4);
    $display("test special channels finished");
    wr(REG_MASK, 32'h1);
    wr(8'h40, 32'h7);
    wr(REG_LEN, 32'h1);
    wr(REG_PERIOD, 32'h4);
    wr(REG_CTRL, 32'h7);
    while (pq.size() < 16) @(posedge mclk);
    chk_word({31'h0, irq}, 32'h1);
    wr(REG_CTRL, 32'h0);
    repeat (4) @(posedge mclk);
    g = pq.size() - DEPTH;
    rd(REG_LEVEL, DEPTH);
    rd(REG_DROP, g / PKT);
    rd(REG_STATUS, 32'h5);
    repeat (DEPTH) rd(REG_DATA, {16'h0, pq.pop_front()});
    rd(REG_STATUS, 32'h2);
    wr(REG_DROP, 32'h0);
    rd(REG_DROP, 32'h0);
    pq.delete();
    p_time.delete();
    wr(REG_CTRL, 32'h7);
    while (pq.size() < 2) @(posedge mclk);
    wr(REG_CTRL, 32'h0);
    repeat (4) @(posedge mclk);
    flush();
    $display("test overflow recovery finished");
    wrap_up();
  end
endmodule : test_stream_scan_acquisition
